// [dccu_pkg.sv]
`default_nettype none
package dccu_pkg;

  // Array geometry: two units of sixteen channels, two timers per unit.
  localparam int NCH  = 32;
  localparam int NUNI = 2;
  localparam int CPU  = 16;
  localparam int NTMR = 4;
  localparam int TW   = 16;
  localparam int AW   = 9;
  localparam int PW   = 10;

  // Register byte offsets.
  localparam logic [AW-1:0] OFS_IRQ_STATUS  = 9'h000;
  localparam logic [AW-1:0] OFS_IRQ_CLEAR   = 9'h004;
  localparam logic [AW-1:0] OFS_IRQ_ENABLE  = 9'h008;
  localparam logic [AW-1:0] OFS_TOVF_STATUS = 9'h00c;
  localparam logic [AW-1:0] OFS_TOVF_CLEAR  = 9'h010;
  localparam logic [AW-1:0] OFS_TOVF_ENABLE = 9'h014;
  // Timer t: control, count and reload words at 0x040 + 16*t.
  localparam logic [2:0]    TMR_PAGE        = 3'h1;
  localparam logic [1:0]    TMR_CTRL        = 2'h0;
  localparam logic [1:0]    TMR_COUNT       = 2'h1;
  localparam logic [1:0]    TMR_RELOAD      = 2'h2;
  // Channel c: configuration and value words at 0x100 + 8*c.
  localparam int            CH_PAGE_BIT     = 8;

  // Channels that own a pin with an output driver.
  localparam logic [NCH-1:0] OUT_CAPABLE    = 32'hf0fff0ff;

  // Timer count sources.
  localparam logic [1:0] SRC_PRESCALE = 2'h0;
  localparam logic [1:0] SRC_EXT_OVF  = 2'h1;
  localparam logic [1:0] SRC_PIN      = 2'h2;

  // Channel mode codes.
  localparam logic [2:0] MODE_OFF      = 3'h0;
  localparam logic [2:0] MODE_CAP_RISE = 3'h1;
  localparam logic [2:0] MODE_CAP_FALL = 3'h2;
  localparam logic [2:0] MODE_CAP_BOTH = 3'h3;
  localparam logic [2:0] MODE_CMP0     = 3'h4;
  localparam logic [2:0] MODE_CMP1     = 3'h5;
  localparam logic [2:0] MODE_CMP2     = 3'h6;
  localparam logic [2:0] MODE_CMP3     = 3'h7;

  // Timer control word layout, low bits of the bus word.
  typedef struct packed {
    logic       run;
    logic [1:0] src;
    logic [2:0] sel;
  } dccu_tcfg_t;
  localparam int TCFG_W = 6;

  // Channel configuration word layout.
  typedef struct packed {
    logic       dbl;
    logic       tsel;
    logic [2:0] mode;
  } dccu_ccfg_t;
  localparam int CCFG_W = 5;

  // Timer state.
  typedef struct packed {
    logic [TW-1:0] count;
    logic [TW-1:0] reload;
    logic          upd;
    logic          ovf;
  } dccu_tmr_t;

  // Channel state.
  typedef struct packed {
    logic [TW-1:0] value;
    logic          fired;
    logic          hit;
  } dccu_ch_t;

  // Top-level state.
  typedef struct packed {
    logic [NCH-1:0]           s1;
    logic [NCH-1:0]           s2;
    logic [NCH-1:0]           s3;
    logic [NUNI-1:0]          t1;
    logic [NUNI-1:0]          t2;
    logic [NUNI-1:0]          t3;
    logic [PW-1:0]            pre;
    logic [NCH-1:0]           pin;
    logic [NCH-1:0]           irq;
    logic [NCH-1:0]           ien;
    logic [NTMR-1:0]          tirq;
    logic [NTMR-1:0]          tien;
    dccu_tcfg_t [NTMR-1:0]    tcfg;
    dccu_ccfg_t [NCH-1:0]     ccfg;
    logic [31:0]              rdata;
    logic                     rd_done;
  } dccu_top_t;

  // Prescaler tick for a division factor of 8 shifted left by the select code.
  function automatic logic presc_tick(input logic [PW-1:0] pre, input logic [2:0] sel);
    logic [PW:0] m;
    m = (11'h008 << sel) - 11'h001;
    return (pre & m[PW-1:0]) == m[PW-1:0];
  endfunction

  // Byte-lane merge of a bus write into an existing word.
  function automatic logic [31:0] be_merge(input logic [31:0] old, input logic [31:0] wd,
                                           input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++)
      if (be[i])
        r[i*8 +: 8] = wd[i*8 +: 8];
    return r;
  endfunction

endpackage
`default_nettype wire

// [dccu_timer.sv]
`timescale 1ns/1ps
`default_nettype none
// One 16-bit time base timer with reload.
module dccu_timer #(
  parameter int TW      = dccu_pkg::TW,
  parameter bit HAS_PIN = 1'b1
) (
  input  wire logic                 clk,
  input  wire logic                 reset,
  input  wire dccu_pkg::dccu_tcfg_t cfg,
  input  wire logic [dccu_pkg::PW-1:0] pre,
  input  wire logic                 ext_ovf,
  input  wire logic                 pin_edge,
  input  wire logic                 wr_count,
  input  wire logic                 wr_reload,
  input  wire logic [TW-1:0]        wdata,
  output logic [TW-1:0]             count,
  output logic [TW-1:0]             reload,
  output logic                      upd,
  output logic                      ovf
);

  // The state layout is fixed by the package, so the width must agree.
  if (TW != dccu_pkg::TW)
  begin : g_chk
    $error("dccu_timer: TW must equal the package timer width.");
  end

  dccu_pkg::dccu_tmr_t q;       // Registered state.
  dccu_pkg::dccu_tmr_t next_q;  // Next state.
  logic                step;    // One count step this cycle.

  ////////////////////////////////////////////////////////////////////////////
  // Count source selection and counting.
  always_comb
  begin
    next_q     = q;
    next_q.upd = 1'b0;
    next_q.ovf = 1'b0;
    case (cfg.src)
      dccu_pkg::SRC_PRESCALE: step = dccu_pkg::presc_tick(pre, cfg.sel);
      dccu_pkg::SRC_EXT_OVF:  step = ext_ovf;
      dccu_pkg::SRC_PIN:      step = HAS_PIN & pin_edge;
      default:                step = 1'b0;
    endcase
    if (cfg.run && step)
    begin
      // The update flag lets the channels compare exactly once per count step.
      next_q.upd = 1'b1;
      if (&q.count)
      begin
        next_q.count = q.reload;
        next_q.ovf   = 1'b1;
      end
      else
        next_q.count = q.count + 1'b1;
    end
    if (wr_reload)
      next_q.reload = wdata;
    // A software load of the count wins over a step in the same cycle.
    if (wr_count)
      next_q.count = wdata;
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register.
  always_ff @(posedge clk)
  begin
    if (reset)
      q <= '0;
    else
      q <= next_q;
  end

  assign count  = q.count;
  assign reload = q.reload;
  assign upd    = q.upd;
  assign ovf    = q.ovf;

endmodule
`default_nettype wire

// [dccu_channel.sv]
`timescale 1ns/1ps
`default_nettype none
// One capture/compare channel register.
module dccu_channel #(
  parameter int TW = dccu_pkg::TW
) (
  input  wire logic                 clk,
  input  wire logic                 reset,
  input  wire dccu_pkg::dccu_ccfg_t cfg,
  input  wire logic [TW-1:0]        cnt_a,
  input  wire logic [TW-1:0]        cnt_b,
  input  wire logic                 upd_a,
  input  wire logic                 upd_b,
  input  wire logic                 ovf_a,
  input  wire logic                 ovf_b,
  input  wire logic                 pin_now,
  input  wire logic                 pin_prev,
  input  wire logic                 wr_val,
  input  wire logic [TW-1:0]        wdata,
  output logic [TW-1:0]             value,
  output logic                      hit
);

  if (TW != dccu_pkg::TW)
  begin : g_chk
    $error("dccu_channel: TW must equal the package timer width.");
  end

  dccu_pkg::dccu_ch_t q;       // Registered state.
  dccu_pkg::dccu_ch_t next_q;  // Next state.
  logic [TW-1:0]      cnt;     // Count of the assigned timer.
  logic               upd;     // Assigned timer took a new value.
  logic               ovf;     // Assigned timer wrapped to reload.
  logic               rise;    // Rising edge on the pin.
  logic               fall;    // Falling edge on the pin.
  logic               match;   // Compare equality on an update.
  logic               once;    // Mode allows one event per period.

  ////////////////////////////////////////////////////////////////////////////
  // Capture, compare and per-period suppression.
  always_comb
  begin
    next_q     = q;
    next_q.hit = 1'b0;
    cnt   = cfg.tsel ? cnt_b : cnt_a;
    upd   = cfg.tsel ? upd_b : upd_a;
    ovf   = cfg.tsel ? ovf_b : ovf_a;
    rise  = pin_now & ~pin_prev;
    fall  = ~pin_now & pin_prev;
    match = upd && (cnt == q.value);
    once  = (cfg.mode == dccu_pkg::MODE_CMP2) || (cfg.mode == dccu_pkg::MODE_CMP3);
    // A new timer period re-arms the one-shot compare modes.
    if (ovf)
      next_q.fired = 1'b0;
    if (wr_val)
      next_q.value = wdata;
    case (cfg.mode)
      dccu_pkg::MODE_CAP_RISE,
      dccu_pkg::MODE_CAP_FALL,
      dccu_pkg::MODE_CAP_BOTH:
      begin
        // A capture wins over a software write in the same cycle.
        if ((rise && cfg.mode != dccu_pkg::MODE_CAP_FALL) ||
            (fall && cfg.mode != dccu_pkg::MODE_CAP_RISE))
        begin
          next_q.value = cnt;
          next_q.hit   = 1'b1;
        end
      end
      dccu_pkg::MODE_CMP0,
      dccu_pkg::MODE_CMP1:
        next_q.hit = match;
      dccu_pkg::MODE_CMP2,
      dccu_pkg::MODE_CMP3:
      begin
        // The match on the reload value itself belongs to the new period.
        if (match && (ovf || !q.fired))
        begin
          next_q.hit   = 1'b1;
          next_q.fired = 1'b1;
        end
      end
      default:
        next_q.hit = 1'b0;
    endcase
    if (!once)
      next_q.fired = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register.
  always_ff @(posedge clk)
  begin
    if (reset)
      q <= '0;
    else
      q <= next_q;
  end

  assign value = q.value;
  assign hit   = q.hit;

endmodule
`default_nettype wire

// [dccu_top.sv]
// The register addresses and the Avalon-MM register port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
//////////////////////////////////////////////////////////////////////////////
module dccu_top (
  input  wire logic                      CLK,
  input  wire logic                      RESET,
  input  wire logic [dccu_pkg::AW-1:0]   AVS_ADDRESS,
  input  wire logic                      AVS_READ,
  input  wire logic                      AVS_WRITE,
  input  wire logic [31:0]               AVS_WRITEDATA,
  input  wire logic [3:0]                AVS_BYTEENABLE,
  output logic [31:0]                    AVS_READDATA,
  output logic                           AVS_WAITREQUEST,
  input  wire logic [dccu_pkg::NCH-1:0]  CC_PIN_IN,
  output logic [dccu_pkg::NCH-1:0]       CC_PIN_OUT,
  output logic [dccu_pkg::NCH-1:0]       CC_PIN_OE,
  input  wire logic [dccu_pkg::NUNI-1:0] TIMER_COUNT_IN,
  input  wire logic                      EXT_TIMER_OVF,
  output logic                           IRQ
);

  localparam int NCH  = dccu_pkg::NCH;
  localparam int NTMR = dccu_pkg::NTMR;
  localparam int TW   = dccu_pkg::TW;
  localparam int CPU  = dccu_pkg::CPU;
  localparam int HALF = dccu_pkg::CPU / 2;

  dccu_pkg::dccu_top_t q;       // Registered state.
  dccu_pkg::dccu_top_t next_q;  // Next state.

  logic [NTMR-1:0][TW-1:0] t_count;   // Timer counts.
  logic [NTMR-1:0][TW-1:0] t_reload;  // Timer reload values.
  logic [NTMR-1:0]         t_upd;     // Timer update pulses.
  logic [NTMR-1:0]         t_ovf;     // Timer overflow pulses.
  logic [NTMR-1:0]         wr_count;  // Software count load.
  logic [NTMR-1:0]         wr_reload; // Software reload write.
  logic [NCH-1:0][TW-1:0]  c_value;   // Channel register values.
  logic [NCH-1:0]          c_hit;     // Channel event pulses.
  logic [NCH-1:0]          wr_val;    // Software channel value write.
  logic [NCH-1:0]          oe;        // Output enables from the modes.
  logic [NTMR-1:0]         tpin;      // Count input edge routed to each timer.
  logic                    acc;       // A write is taken this cycle.
  logic                    ch_page;   // Address lies in the channel page.
  logic                    t_page;    // Address lies in the timer page.
  logic [4:0]              ch_idx;    // Addressed channel.
  logic [1:0]              t_idx;     // Addressed timer.
  logic [31:0]             rd_mux;    // Read data before registering.
  logic [31:0]             wd;        // Byte-lane merged write word.

  ////////////////////////////////////////////////////////////////////////////
  // Address decode shared by reads and writes.
  assign ch_page = AVS_ADDRESS[dccu_pkg::CH_PAGE_BIT];
  assign t_page  = !ch_page && (AVS_ADDRESS[8:6] == dccu_pkg::TMR_PAGE);
  assign ch_idx  = AVS_ADDRESS[7:3];
  assign t_idx   = AVS_ADDRESS[5:4];
  assign acc     = AVS_WRITE;
  // Narrow fields take only the low byte lanes that carry them.
  assign wd      = dccu_pkg::be_merge(32'h0000_0000, AVS_WRITEDATA, AVS_BYTEENABLE);

  // Count-input edges; only the first timer of each base listens to one.
  assign tpin = {1'b0, q.t2[1] & ~q.t3[1], 1'b0, q.t2[0] & ~q.t3[0]};

  ////////////////////////////////////////////////////////////////////////////
  // Write strobes into the timers and channels.
  always_comb
  begin
    wr_count  = '0;
    wr_reload = '0;
    wr_val    = '0;
    if (acc && t_page)
    begin
      wr_count[t_idx]  = (AVS_ADDRESS[3:2] == dccu_pkg::TMR_COUNT);
      wr_reload[t_idx] = (AVS_ADDRESS[3:2] == dccu_pkg::TMR_RELOAD);
    end
    if (acc && ch_page && AVS_ADDRESS[2])
      wr_val[ch_idx] = 1'b1;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Timers: two per unit, all sharing one prescaler.
  for (genvar t = 0; t < NTMR; t++)
  begin : g_tmr
    dccu_timer #(
      .TW      (TW),
      .HAS_PIN ((t % 2) == 0)
    ) u_tmr (
      .clk       (CLK),
      .reset     (RESET),
      .cfg       (q.tcfg[t]),
      .pre       (q.pre),
      .ext_ovf   (EXT_TIMER_OVF),
      .pin_edge  (tpin[t]),
      .wr_count  (wr_count[t]),
      .wr_reload (wr_reload[t]),
      .wdata     (wd[TW-1:0]),
      .count     (t_count[t]),
      .reload    (t_reload[t]),
      .upd       (t_upd[t]),
      .ovf       (t_ovf[t])
    );
  end

  ////////////////////////////////////////////////////////////////////////////
  // Channels: each unit's sixteen channels see only its own timer pair.
  for (genvar c = 0; c < NCH; c++)
  begin : g_ch
    localparam int TA = 2 * (c / CPU);
    dccu_channel #(
      .TW (TW)
    ) u_ch (
      .clk      (CLK),
      .reset    (RESET),
      .cfg      (q.ccfg[c]),
      .cnt_a    (t_count[TA]),
      .cnt_b    (t_count[TA+1]),
      .upd_a    (t_upd[TA]),
      .upd_b    (t_upd[TA+1]),
      .ovf_a    (t_ovf[TA]),
      .ovf_b    (t_ovf[TA+1]),
      .pin_now  (q.s2[c]),
      .pin_prev (q.s3[c]),
      .wr_val   (wr_val[c]),
      .wdata    (wd[TW-1:0]),
      .value    (c_value[c]),
      .hit      (c_hit[c])
    );
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read multiplexer; unmapped words and reserved bits read as zero.
  always_comb
  begin
    rd_mux = 32'h0000_0000;
    if (ch_page)
    begin
      if (AVS_ADDRESS[2])
        rd_mux[TW-1:0] = c_value[ch_idx];
      else
        rd_mux[dccu_pkg::CCFG_W-1:0] = q.ccfg[ch_idx];
    end
    else if (t_page)
    begin
      case (AVS_ADDRESS[3:2])
        dccu_pkg::TMR_CTRL:   rd_mux[dccu_pkg::TCFG_W-1:0] = q.tcfg[t_idx];
        dccu_pkg::TMR_COUNT:  rd_mux[TW-1:0] = t_count[t_idx];
        dccu_pkg::TMR_RELOAD: rd_mux[TW-1:0] = t_reload[t_idx];
        default:              rd_mux = 32'h0000_0000;
      endcase
    end
    else
    begin
      case (AVS_ADDRESS)
        dccu_pkg::OFS_IRQ_STATUS:  rd_mux = q.irq;
        dccu_pkg::OFS_IRQ_ENABLE:  rd_mux = q.ien;
        dccu_pkg::OFS_TOVF_STATUS: rd_mux[NTMR-1:0] = q.tirq;
        dccu_pkg::OFS_TOVF_ENABLE: rd_mux[NTMR-1:0] = q.tien;
        default:                   rd_mux = 32'h0000_0000;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin outputs and enables from the compare modes.
  always_comb
  begin
    oe = '0;
    for (int c = 0; c < NCH; c++)
    begin
      if (q.ccfg[c].mode == dccu_pkg::MODE_CMP1 || q.ccfg[c].mode == dccu_pkg::MODE_CMP3)
        oe[c] = 1'b1;
      // The lower channel of a pair drives the shared pin.
      if ((c % CPU) < HALF && q.ccfg[c].dbl)
        oe[c] = 1'b1;
    end
    // Input-only channels never drive, whatever their mode.
    oe = oe & dccu_pkg::OUT_CAPABLE;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Next state: synchronisers, prescaler, pin actions, flags and registers.
  always_comb
  begin
    next_q = q;
    // Pins pass two flops before any logic; the third holds the old level.
    next_q.s1 = CC_PIN_IN;
    next_q.s2 = q.s1;
    next_q.s3 = q.s2;
    next_q.t1 = TIMER_COUNT_IN;
    next_q.t2 = q.t1;
    next_q.t3 = q.t2;
    // One free-running prescaler serves every timer, so rates stay in phase.
    next_q.pre = q.pre + 1'b1;

    // Pin actions.
    for (int c = 0; c < NCH; c++)
    begin
      case (q.ccfg[c].mode)
        dccu_pkg::MODE_CMP1:
          if (c_hit[c])
            next_q.pin[c] = ~q.pin[c];
        dccu_pkg::MODE_CMP3:
        begin
          // Overflow clears first so that a hit arriving in the same cycle sets.
          if (t_ovf[2 * (c / CPU) + (q.ccfg[c].tsel ? 1 : 0)])
            next_q.pin[c] = 1'b0;
          if (c_hit[c])
            next_q.pin[c] = 1'b1;
        end
        default:
          next_q.pin[c] = q.pin[c];
      endcase
      // The wrapped index keeps the partner lookup in range for every channel.
      if ((c % CPU) < HALF && q.ccfg[c].dbl && (c_hit[c] || c_hit[(c + HALF) % NCH]))
        next_q.pin[c] = ~q.pin[c];
    end

    // Software clears first, so an event in the same cycle is kept.
    if (acc && AVS_ADDRESS == dccu_pkg::OFS_IRQ_CLEAR)
      next_q.irq = q.irq & ~wd;
    if (acc && AVS_ADDRESS == dccu_pkg::OFS_TOVF_CLEAR)
      next_q.tirq = q.tirq & ~wd[NTMR-1:0];
    // Mode 1 and 3 are pin actions, but their events still flag the channel.
    next_q.irq  = next_q.irq | c_hit;
    next_q.tirq = next_q.tirq | t_ovf;

    // Register writes.
    if (acc && AVS_ADDRESS == dccu_pkg::OFS_IRQ_ENABLE)
      next_q.ien = wd;
    if (acc && AVS_ADDRESS == dccu_pkg::OFS_TOVF_ENABLE)
      next_q.tien = wd[NTMR-1:0];
    if (acc && t_page && AVS_ADDRESS[3:2] == dccu_pkg::TMR_CTRL)
      next_q.tcfg[t_idx] = dccu_pkg::dccu_tcfg_t'(wd[dccu_pkg::TCFG_W-1:0]);
    if (acc && ch_page && !AVS_ADDRESS[2])
      next_q.ccfg[ch_idx] = dccu_pkg::dccu_ccfg_t'(wd[dccu_pkg::CCFG_W-1:0]);

    // Reads take one wait cycle so the data come from a register.
    next_q.rd_done = AVS_READ && !q.rd_done;
    if (AVS_READ && !q.rd_done)
      next_q.rdata = rd_mux;
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register.
  always_ff @(posedge CLK)
  begin
    if (RESET)
      q <= '0;
    else
      q <= next_q;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs.
  assign AVS_READDATA    = q.rdata;
  assign AVS_WAITREQUEST = AVS_READ && !q.rd_done;
  assign CC_PIN_OUT      = q.pin & oe;
  assign CC_PIN_OE       = oe;
  assign IRQ             = |(q.irq & q.ien) || |(q.tirq & q.tien);

endmodule
`default_nettype wire

// [dccu_sva.sv]
`timescale 1ns/1ps
`default_nettype none
////////////////////////////////////////////////////////////
// Port checks of the bus handshake and the pin drivers.
module dccu_sva (
  input wire logic        CLK,
  input wire logic        RESET,
  input wire logic        AVS_READ,
  input wire logic        AVS_WRITE,
  input wire logic        AVS_WAITREQUEST,
  input wire logic [31:0] AVS_READDATA,
  input wire logic [31:0] CC_PIN_OUT,
  input wire logic [31:0] CC_PIN_OE,
  input wire logic        IRQ
);
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (RESET);
  // A read stalls one cycle, then answers.
  sequence s_stall;
    AVS_WAITREQUEST;
  endsequence
  sequence s_answer;
    !AVS_WAITREQUEST;
  endsequence
  AST_RD_ONEWAIT: assert property ($rose(AVS_READ) |-> s_stall ##1 s_answer)
    else $error("read did not answer after one wait");
  AST_WR_NOWAIT: assert property (AVS_WRITE |-> !AVS_WAITREQUEST)
    else $error("write stalled");
  AST_IDLE_NOWAIT: assert property (!AVS_READ |-> !AVS_WAITREQUEST)
    else $error("wait without a read");
  AST_RDATA_HOLD: assert property (!AVS_READ |=> $stable(AVS_READDATA))
    else $error("read data moved between reads");
  AST_OE_INONLY: assert property (CC_PIN_OE[11:8] == 4'h0 && CC_PIN_OE[27:24] == 4'h0)
    else $error("input-only pin driven");
  AST_OUT_OE: assert property ((CC_PIN_OUT & ~CC_PIN_OE) == 32'h0)
    else $error("pin level without enable");
  // Enables follow configuration, so they only move after a write.
  AST_OE_CFG: assert property (!$stable(CC_PIN_OE) |-> $past(AVS_WRITE))
    else $error("pin enable moved without a write");
  AST_RST_QUIET: assert property ($fell(RESET) |-> !IRQ && CC_PIN_OE == 32'h0)
    else $error("not quiet after reset");
endmodule
bind dccu_top dccu_sva i_sva (.CLK(CLK), .RESET(RESET), .AVS_READ(AVS_READ),
  .AVS_WRITE(AVS_WRITE), .AVS_WAITREQUEST(AVS_WAITREQUEST), .AVS_READDATA(AVS_READDATA),
  .CC_PIN_OUT(CC_PIN_OUT), .CC_PIN_OE(CC_PIN_OE), .IRQ(IRQ));
`default_nettype wire

// [dccu_pin_model.sv]
`timescale 1ns/1ps
`default_nettype none
// Outside world of the channel pins.
module dccu_pin_model (
  input  wire logic [31:0] lvl,
  input  wire logic [31:0] out,
  input  wire logic [31:0] oe,
  output logic [31:0]      pin
);
  // A driven pin shows the unit's level; an undriven one the outside source.
  assign pin = (oe & out) | (~oe & lvl);
endmodule
`default_nettype wire

// [dual_capture_compare_unit_bench.sv]
`timescale 1ns/1ps
`default_nettype none
module dual_capture_compare_unit_bench;
  logic        CLK = 1'b0, RESET = 1'b1, AVS_READ = 1'b0, AVS_WRITE = 1'b0;
  logic        EXT_TIMER_OVF = 1'b0, IRQ, AVS_WAITREQUEST;
  logic [8:0]  AVS_ADDRESS = 9'h000;
  logic [3:0]  AVS_BYTEENABLE = 4'hf;
  logic [1:0]  TIMER_COUNT_IN = 2'h0;
  logic [31:0] AVS_WRITEDATA = 32'h0, AVS_READDATA, CC_PIN_IN, CC_PIN_OUT, CC_PIN_OE;
  logic [31:0] lvl = 32'h0, rnd = 32'h93a3, e_val, q_exp[$];
  logic [15:0] v;
  int          n_mismatch = 0, num_checks = 0;
  always #5 CLK = ~CLK;
  dccu_top i_dut (.CLK(CLK), .RESET(RESET), .AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ),
    .AVS_WRITE(AVS_WRITE), .AVS_WRITEDATA(AVS_WRITEDATA), .AVS_BYTEENABLE(AVS_BYTEENABLE),
    .AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST), .CC_PIN_IN(CC_PIN_IN),
    .CC_PIN_OUT(CC_PIN_OUT), .CC_PIN_OE(CC_PIN_OE), .TIMER_COUNT_IN(TIMER_COUNT_IN),
    .EXT_TIMER_OVF(EXT_TIMER_OVF), .IRQ(IRQ));
  dccu_pin_model i_pins (.lvl(lvl), .out(CC_PIN_OUT), .oe(CC_PIN_OE), .pin(CC_PIN_IN));
  ////////////////////////////////////////////////////////////
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // One bus access; the request stands until waitrequest is seen low.
  task automatic bus(input logic rd, input logic [8:0] a, input logic [31:0] d);
    int n;
    @(posedge CLK);
    AVS_ADDRESS <= a;
    AVS_WRITEDATA <= d;
    AVS_READ <= rd;
    AVS_WRITE <= !rd;
    n = 0;
    do
    begin
      @(posedge CLK);
      n++;
    end while (AVS_WAITREQUEST !== 1'b0 && n < 20);
    if (n >= 20)
    begin
      n_mismatch++;
      test_done();
    end
    AVS_READ <= 1'b0;
    AVS_WRITE <= 1'b0;
  endtask
  task automatic wr(input logic [8:0] a, input logic [31:0] d);
    bus(1'b0, a, d);
  endtask
  // The expected word is noted before the read goes out.
  task automatic rd(input logic [8:0] a, input logic [31:0] e);
    q_exp.push_back(e);
    bus(1'b1, a, 32'h0);
  endtask
  // Runs timer 0 for exactly two ticks of the fastest prescale.
  task automatic run2;
    wr(9'h040, 32'h20);
    repeat (14) @(posedge CLK);
    wr(9'h040, 32'h0);
  endtask
  // Read results are compared in the cycle that carries them.
  always @(posedge CLK)
    if (AVS_READ === 1'b1 && AVS_WAITREQUEST === 1'b0)
      chk("readdata", q_exp.pop_front(), AVS_READDATA);
  ////////////////////////////////////////////////////////////
  initial
  begin
    repeat (6) @(posedge CLK);
    RESET <= 1'b0;
    rd(dccu_pkg::OFS_IRQ_STATUS, 32'h0);
    rd(9'h018, 32'h0);
    // A window of 2*factor cycles holds exactly two prescaler ticks.
    for (int s = 0; s < 8; s++)
    begin
      wr(9'h044, 32'h0);
      wr(9'h040, 32'h20 | 32'(s));
      repeat ((16 << s) - 2) @(posedge CLK);
      wr(9'h040, 32'(s));
      rd(9'h044, 32'h2);
    end
    // Overflow pulses, then the count pin, each three events.
    for (int s = 1; s < 3; s++)
    begin
      wr(9'h044, 32'h0);
      wr(9'h040, 32'h20 | 32'(s << 3));
      repeat (3)
      begin
        @(posedge CLK);
        EXT_TIMER_OVF <= (s == 1);
        TIMER_COUNT_IN <= {1'b0, s == 2};
        @(posedge CLK);
        EXT_TIMER_OVF <= 1'b0;
        repeat (4) @(posedge CLK);
        TIMER_COUNT_IN <= 2'h0;
        repeat (4) @(posedge CLK);
      end
      wr(9'h040, 32'(s << 3));
      rd(9'h044, 32'h3);
    end
    rnd = lfsr(rnd);
    wr(9'h048, {16'h0, rnd[15:0]});
    wr(9'h044, 32'hfffe);
    wr(dccu_pkg::OFS_TOVF_ENABLE, 32'h1);
    run2();
    rd(9'h044, {16'h0, rnd[15:0]});
    rd(dccu_pkg::OFS_TOVF_STATUS, 32'h1);
    wr(dccu_pkg::OFS_IRQ_ENABLE, 32'h3);
    chk("irq", 32'h1, {31'h0, IRQ});
    wr(dccu_pkg::OFS_TOVF_CLEAR, 32'h1);
    @(posedge CLK);
    chk("irq", 32'h0, {31'h0, IRQ});
    // Capture on channel 0: a rise, then a fall, each with a new count.
    e_val = 32'h0;
    for (int m = 1; m < 4; m++)
    begin
      wr(9'h100, 32'(m));
      for (int e = 0; e < 2; e++)
      begin
        rnd = lfsr(rnd);
        wr(9'h044, {16'h0, rnd[15:0]});
        if (m == 3 || m == e + 1)
          e_val = {16'h0, rnd[15:0]};
        lvl[0] <= (e == 0);
        repeat (8) @(posedge CLK);
      end
      rd(9'h104, e_val);
      rd(dccu_pkg::OFS_IRQ_STATUS, 32'h1);
      wr(dccu_pkg::OFS_IRQ_CLEAR, 32'h1);
    end
    // Compare on channel 1: two matches in one period.
    for (int m = 4; m < 8; m++)
    begin
      rnd = lfsr(rnd);
      v = {1'b0, rnd[14:0]} + 16'h0010;
      // A pass through mode 0 re-arms the one-shot left over from mode 2.
      wr(9'h108, 32'h4);
      wr(9'h10c, {16'h0, v});
      wr(9'h108, 32'(m));
      for (int p = 0; p < 2; p++)
      begin
        wr(9'h044, {16'h0, v - 16'h0001});
        run2();
        repeat (3) @(posedge CLK);
        chk("pin", {30'h0, m[0], (m == 5 && p == 0) || m == 7},
            {30'h0, CC_PIN_OE[1], CC_PIN_OUT[1]});
        rd(dccu_pkg::OFS_IRQ_STATUS, (p == 0 || m < 6) ? 32'h2 : 32'h0);
        wr(dccu_pkg::OFS_IRQ_CLEAR, 32'h2);
      end
    end
    // An overflow with no match drops a set/clear pin.
    wr(9'h048, 32'h0);
    wr(9'h044, 32'hffff);
    run2();
    repeat (3) @(posedge CLK);
    chk("pin", 32'h2, {30'h0, CC_PIN_OE[1], CC_PIN_OUT[1]});
    // Double register: one match on channel 8 toggles the pin of channel 0.
    wr(9'h144, 32'h5);
    wr(9'h140, 32'h4);
    wr(9'h100, 32'h10);
    wr(9'h044, 32'h4);
    run2();
    repeat (3) @(posedge CLK);
    chk("pin", 32'h3, {30'h0, CC_PIN_OE[0], CC_PIN_OUT[0]});
    test_done();
  end
  // Cuts a hang short.
  initial
  begin
    repeat (100000) @(posedge CLK);
    n_mismatch++;
    test_done();
  end
endmodule
`default_nettype wire
